// ---- emsq_pkg.sv ----
// constants, field layout and state types for the external memory strobe sequencer
package emsq_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int SPACES = 4;
   localparam int LANES = 4;
   localparam int CNT_W = 4;
   localparam int SEQ_W = 8;
   localparam int LEN_W = 3;
   localparam int BURST_WORDS = 4;
   localparam int WB_AW = 8;

   // register pages (address bits 7:4) and register byte addresses
   localparam logic [3:0] PAGE_SPACE_CFG = 4'h0;
   localparam logic [3:0] PAGE_WDATA = 4'h2;
   localparam logic [3:0] PAGE_RDATA = 4'h3;
   localparam logic [WB_AW-1:0] OFS_ACC_ADDR = 8'h10;
   localparam logic [WB_AW-1:0] OFS_ACC_CMD = 8'h14;
   localparam logic [WB_AW-1:0] OFS_STATUS = 8'h18;

   // space configuration fields
   localparam int F_TYPE_LO = 0;
   localparam int F_RSU_LO = 4;
   localparam int F_RSB_LO = 8;
   localparam int F_RHD_LO = 12;
   localparam int F_WSU_LO = 16;
   localparam int F_WSB_LO = 20;
   localparam int F_WHD_LO = 24;
   localparam logic [DATA_W-1:0] SPACE_CFG_RESET = 32'h0fff_fff0;

   // access address and command fields
   localparam int F_WADDR_LO = 2;
   localparam int F_SPACE_LO = 24;
   localparam int F_GO = 0;
   localparam int F_WRITE = 1;
   localparam int F_BE_LO = 4;
   localparam int F_LEN_LO = 8;
   localparam int F_BUSY = 0;

   // read latency of the synchronous memories, in memory clocks
   localparam int SB_RD_LAT = 2;
   localparam int SD_CAS_LAT = 3;

   typedef enum logic [1:0] {
      MT_ASYNC = 2'b00,
      MT_SBSRAM = 2'b01,
      MT_SDRAM = 2'b10,
      MT_RSVD = 2'b11
   } emsq_mtype_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_HOLD = 3'b011,
      ST_ACT = 3'b100,
      ST_XFER = 3'b101,
      ST_DRAIN = 3'b110
   } emsq_state_t;
endpackage

// ---- emsq_top.sv ----
// external memory strobe sequencer: wishbone registers plus memory-clock pin sequencer
`timescale 1ns/1ps
// Notes on behaviour
// - async read: selects valid read-setup periods before read strobe falls
// - async read: selects unchanged read-hold periods after read strobe rises
// - async write: selects and data held write-hold periods after write strobe
// - late silicon: write data appears write-setup minus one periods before strobe
// - select group: chip enables, byte enables, word address, async output enable
// - async: shared pins act as read strobe, output enable, write strobe
// - burst sram: shared pins act as address strobe, output enable, write enable
// - async strobe edges launch from rising memory clock edges
// - burst sram outputs change only after rising memory clock edges
// - synchronous reads capture data on rising memory clock edge
// - burst sram advances burst address with its own counter
// - sdram advances burst address with its own counter
// - synchronous accesses default to incrementing four-word bursts
// - shorter sequences come from the command length field ending the transfer early
// - burst words move every clock with no gaps
// - setup, strobe and hold counts come from per-space config registers
// - ready input is synchronised through two flops and acted on two memory clocks after it is sampled
module emsq_top #(
   parameter logic LATE_DATA = 1'b1,
   parameter int SB_LAT = emsq_pkg::SB_RD_LAT,
   parameter int SD_LAT = emsq_pkg::SD_CAS_LAT
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [emsq_pkg::WB_AW-1:0] i_wb_adr,
   input wire logic [emsq_pkg::DATA_W-1:0] i_wb_dat,
   input wire logic [emsq_pkg::LANES-1:0] i_wb_sel,
   output logic [emsq_pkg::DATA_W-1:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_mem_clock_in,
   output logic o_mem_clock_out,
   output logic [emsq_pkg::SPACES-1:0] o_chip_space_enable_n,
   output logic [emsq_pkg::LANES-1:0] o_byte_lane_enable_n,
   output logic [emsq_pkg::ADDR_W-1:0] o_mem_word_address,
   output logic [emsq_pkg::DATA_W-1:0] o_mem_data_bus,
   output logic o_mem_data_bus_oe_n,
   input wire logic [emsq_pkg::DATA_W-1:0] i_mem_data_bus,
   output logic o_shared_pin_a_n,
   output logic o_shared_pin_b_n,
   output logic o_shared_pin_c_n,
   input wire logic i_async_ready_in
);
   import emsq_pkg::*;

   // ---------------- bus domain ----------------
   logic [DATA_W-1:0] space_cfg [SPACES];
   logic [DATA_W-1:0] wdata [BURST_WORDS];
   logic [DATA_W-1:0] rdata [BURST_WORDS];
   logic [DATA_W-1:0] acc_addr;
   logic [DATA_W-1:0] acc_cmd;
   logic busy;
   logic req_tgl;
   logic done_s1, done_s2, done_s3;
   // snapshot handed to the memory domain, frozen while busy
   logic [DATA_W-1:0] req_cfg;
   logic [DATA_W-1:0] req_addr;
   logic [DATA_W-1:0] req_cmd;
   logic [DATA_W-1:0] req_wd [BURST_WORDS];
   logic [DATA_W-1:0] rd_word [BURST_WORDS];
   logic done_tgl;

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [LANES-1:0] sel);
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int b = 0; b < LANES; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // address decode; unmapped reads return zero and writes are dropped
   wire take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire wr_take = take & i_wb_we;
   wire [3:0] page = i_wb_adr[7:4];
   wire [1:0] widx = i_wb_adr[3:2];
   wire hit_cfg = (page == PAGE_SPACE_CFG);
   wire hit_wd = (page == PAGE_WDATA);
   wire hit_rd = (page == PAGE_RDATA);
   wire hit_addr = (i_wb_adr == OFS_ACC_ADDR);
   wire hit_cmd = (i_wb_adr == OFS_ACC_CMD);
   wire hit_stat = (i_wb_adr == OFS_STATUS);
   wire [DATA_W-1:0] cmd_new = merge(acc_cmd, i_wb_dat, i_wb_sel);
   // a go while busy is refused so the frozen snapshot stays coherent
   wire go = wr_take & hit_cmd & cmd_new[F_GO] & ~busy;
   wire done_edge = done_s2 ^ done_s3;
   wire [1:0] sel_space = acc_addr[F_SPACE_LO +: 2];
   wire [DATA_W-1:0] rd_mux =
      hit_cfg ? space_cfg[widx] :
      hit_wd ? wdata[widx] :
      hit_rd ? rdata[widx] :
      hit_addr ? acc_addr :
      hit_cmd ? {acc_cmd[DATA_W-1:1], 1'b0} :
      hit_stat ? {{(DATA_W-1){1'b0}}, busy} : '0;

   // single-wait-state slave: ack one cycle after the request is taken
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end else begin
         o_wb_ack <= take;
         if (take) begin
            o_wb_dat <= rd_mux;
         end
      end
   end

   // per-space timing registers and access staging
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int k = 0; k < SPACES; k++) begin
            space_cfg[k] <= SPACE_CFG_RESET;
         end
         for (int k = 0; k < BURST_WORDS; k++) begin
            wdata[k] <= '0;
         end
         acc_addr <= '0;
         acc_cmd <= '0;
      end else if (wr_take) begin
         if (hit_cfg) space_cfg[widx] <= merge(space_cfg[widx], i_wb_dat, i_wb_sel);
         if (hit_wd) wdata[widx] <= merge(wdata[widx], i_wb_dat, i_wb_sel);
         if (hit_addr) acc_addr <= merge(acc_addr, i_wb_dat, i_wb_sel);
         if (hit_cmd) acc_cmd <= cmd_new;
      end
   end

   // request toggle out, done toggle back through two flops
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy <= 1'b0;
         req_tgl <= 1'b0;
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
         req_cfg <= '0;
         req_addr <= '0;
         req_cmd <= '0;
         for (int k = 0; k < BURST_WORDS; k++) begin
            req_wd[k] <= '0;
            rdata[k] <= '0;
         end
      end else begin
         done_s1 <= done_tgl;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
         if (go) begin
            busy <= 1'b1;
            req_tgl <= ~req_tgl;
            req_cfg <= space_cfg[sel_space];
            req_addr <= acc_addr;
            req_cmd <= cmd_new;
            for (int k = 0; k < BURST_WORDS; k++) begin
               req_wd[k] <= wdata[k];
            end
         end else if (done_edge) begin
            busy <= 1'b0;
            for (int k = 0; k < BURST_WORDS; k++) begin
               rdata[k] <= rd_word[k];
            end
         end
      end
   end

   // ---------------- memory clock domain ----------------
   emsq_state_t st;
   logic [SEQ_W-1:0] cnt;
   logic req_s1, req_s2, req_s3;
   logic rdy_s1, rdy_s2;

   // request words are frozen in the bus domain while busy, so read directly
   wire emsq_mtype_t mtype = emsq_mtype_t'(req_cfg[F_TYPE_LO +: 2]);
   wire is_sdram = (mtype == MT_SDRAM);
   wire is_sbsram = (mtype == MT_SBSRAM);
   wire is_write = req_cmd[F_WRITE];
   wire [1:0] req_space = req_addr[F_SPACE_LO +: 2];
   wire [LEN_W-1:0] len_raw = req_cmd[F_LEN_LO +: LEN_W];
   // zero or oversize length means the default full burst
   wire [LEN_W-1:0] len = (len_raw == '0 || len_raw > LEN_W'(BURST_WORDS)) ?
                          LEN_W'(BURST_WORDS) : len_raw;
   wire [SEQ_W-1:0] len8 = SEQ_W'(len);
   wire [SEQ_W-1:0] lat = is_sdram ? SEQ_W'(SD_LAT) : SEQ_W'(SB_LAT);
   // a zero count is treated as one period so every phase is visible
   wire [CNT_W-1:0] setup_raw = is_write ? req_cfg[F_WSU_LO +: CNT_W] : req_cfg[F_RSU_LO +: CNT_W];
   wire [CNT_W-1:0] strb_raw = is_write ? req_cfg[F_WSB_LO +: CNT_W] : req_cfg[F_RSB_LO +: CNT_W];
   wire [CNT_W-1:0] hold_raw = is_write ? req_cfg[F_WHD_LO +: CNT_W] : req_cfg[F_RHD_LO +: CNT_W];
   wire [SEQ_W-1:0] setup_n = (setup_raw == '0) ? SEQ_W'(1) : SEQ_W'(setup_raw);
   wire [SEQ_W-1:0] strb_n = (strb_raw == '0) ? SEQ_W'(1) : SEQ_W'(strb_raw);
   wire [SEQ_W-1:0] hold_n = (hold_raw == '0) ? SEQ_W'(1) : SEQ_W'(hold_raw);
   wire req_edge = req_s2 ^ req_s3;
   wire strobe_end = (st == ST_STROBE) && (cnt == strb_n - SEQ_W'(1)) && rdy_s2;
   wire [1:0] nxt_word = cnt[1:0] + 2'b01;
   wire [SEQ_W-1:0] cap_off = cnt - lat;
   wire cap_en = ((st == ST_XFER) || (st == ST_DRAIN)) && !is_write &&
                 (cnt >= lat) && (cap_off < len8);

   // the memory clock is forwarded so pin launches line up with its rising edge
   assign o_mem_clock_out = i_mem_clock_in;

   // request toggle and ready pin each pass two flops before use
   always_ff @(posedge i_mem_clock_in or negedge i_rst_b) begin
      if (!i_rst_b) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         rdy_s1 <= i_async_ready_in;
         rdy_s2 <= rdy_s1;
      end
   end

   // pin sequencer; every pin is a flop on the memory clock
   always_ff @(posedge i_mem_clock_in or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= ST_IDLE;
         cnt <= '0;
         done_tgl <= 1'b0;
         o_chip_space_enable_n <= '1;
         o_byte_lane_enable_n <= '1;
         o_mem_word_address <= '0;
         o_mem_data_bus <= '0;
         o_mem_data_bus_oe_n <= 1'b1;
         o_shared_pin_a_n <= 1'b1;
         o_shared_pin_b_n <= 1'b1;
         o_shared_pin_c_n <= 1'b1;
      end else begin
         unique case (st)
            ST_IDLE: begin
               if (req_edge) begin
                  cnt <= '0;
                  o_chip_space_enable_n <= ~(SPACES'(1) << req_space);
                  o_byte_lane_enable_n <= ~req_cmd[F_BE_LO +: LANES];
                  o_mem_word_address <= req_addr[F_WADDR_LO +: ADDR_W];
                  o_mem_data_bus <= req_wd[0];
                  if (is_sdram) begin
                     st <= ST_ACT;
                     o_shared_pin_b_n <= 1'b0; // row strobe
                  end else if (is_sbsram) begin
                     st <= ST_XFER;
                     o_shared_pin_a_n <= 1'b0; // address strobe
                     o_shared_pin_b_n <= is_write;
                     o_shared_pin_c_n <= ~is_write;
                     o_mem_data_bus_oe_n <= ~is_write;
                  end else begin
                     st <= ST_SETUP;
                     o_shared_pin_b_n <= is_write; // output enable is a select
                     // late parts hold data back one period
                     o_mem_data_bus_oe_n <= ~(is_write & ~LATE_DATA);
                  end
               end
            end
            ST_SETUP: begin
               o_mem_data_bus_oe_n <= ~is_write;
               if (cnt == setup_n - SEQ_W'(1)) begin
                  st <= ST_STROBE;
                  cnt <= '0;
                  o_shared_pin_a_n <= is_write;
                  o_shared_pin_c_n <= ~is_write;
               end else begin
                  cnt <= cnt + SEQ_W'(1);
               end
            end
            ST_STROBE: begin
               if (cnt != strb_n - SEQ_W'(1)) begin
                  cnt <= cnt + SEQ_W'(1);
               end else if (rdy_s2) begin // ready low stretches the strobe
                  st <= ST_HOLD;
                  cnt <= '0;
                  o_shared_pin_a_n <= 1'b1;
                  o_shared_pin_c_n <= 1'b1;
               end
            end
            ST_HOLD: begin
               // selects and data frozen until the hold count runs out
               if (cnt == hold_n - SEQ_W'(1)) begin
                  st <= ST_IDLE;
                  done_tgl <= ~done_tgl;
                  o_chip_space_enable_n <= '1;
                  o_byte_lane_enable_n <= '1;
                  o_shared_pin_b_n <= 1'b1;
                  o_mem_data_bus_oe_n <= 1'b1;
               end else begin
                  cnt <= cnt + SEQ_W'(1);
               end
            end
            ST_ACT: begin
               st <= ST_XFER;
               o_shared_pin_b_n <= 1'b1;
               o_shared_pin_a_n <= 1'b0; // column strobe
               o_shared_pin_c_n <= ~is_write;
               o_mem_data_bus_oe_n <= ~is_write;
            end
            ST_XFER: begin
               // address is issued once; the memory counts the burst
               cnt <= cnt + SEQ_W'(1);
               o_shared_pin_a_n <= 1'b1;
               if (is_sdram) o_shared_pin_c_n <= 1'b1;
               o_mem_data_bus <= req_wd[nxt_word]; // a new word every clock
               if (cnt == len8 - SEQ_W'(1)) begin
                  o_shared_pin_c_n <= 1'b1;
                  o_mem_data_bus_oe_n <= 1'b1;
                  if (is_write) begin
                     st <= ST_IDLE;
                     done_tgl <= ~done_tgl;
                     o_chip_space_enable_n <= '1;
                     o_byte_lane_enable_n <= '1;
                     o_shared_pin_b_n <= 1'b1;
                  end else begin
                     st <= ST_DRAIN;
                  end
               end
            end
            ST_DRAIN: begin
               cnt <= cnt + SEQ_W'(1);
               if (cnt == lat + len8 - SEQ_W'(1)) begin
                  st <= ST_IDLE;
                  done_tgl <= ~done_tgl;
                  o_chip_space_enable_n <= '1;
                  o_byte_lane_enable_n <= '1;
                  o_shared_pin_b_n <= 1'b1;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // read capture; one slot per burst word
   for (genvar k = 0; k < BURST_WORDS; k++) begin : g_cap
      always_ff @(posedge i_mem_clock_in or negedge i_rst_b) begin
         if (!i_rst_b) begin
            rd_word[k] <= '0;
         end else if (cap_en && cap_off[1:0] == 2'(k)) begin
            rd_word[k] <= i_mem_data_bus;
         end else if (k == 0 && strobe_end && !is_write) begin
            rd_word[k] <= i_mem_data_bus; // async data taken as strobe ends
         end
      end
   end

   // ---------------- checks ----------------
   a_select_stable_async: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      (st == ST_STROBE || st == ST_HOLD) && $past(st) != ST_SETUP |->
      $stable(o_mem_word_address) && $stable(o_chip_space_enable_n) &&
      $stable(o_byte_lane_enable_n)) else $error("select moved in strobe or hold");
   a_setup_len_ok: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      $rose(st == ST_STROBE) |-> $past(cnt) == setup_n - SEQ_W'(1))
      else $error("setup phase length wrong");
   a_hold_len_ok: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_HOLD |-> cnt < hold_n) else $error("hold phase overran");
   a_hold_pins_kept: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_HOLD && is_write |-> !o_mem_data_bus_oe_n && o_shared_pin_c_n &&
      o_chip_space_enable_n != '1) else $error("write hold lost data or select");
   a_late_write_data: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      $rose(st == ST_SETUP) && is_write && LATE_DATA |-> o_mem_data_bus_oe_n)
      else $error("write data driven too early");
   a_strobe_stretch: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_STROBE && cnt == strb_n - SEQ_W'(1) && !rdy_s2 |=>
      st == ST_STROBE && (!o_shared_pin_a_n || !o_shared_pin_c_n))
      else $error("strobe ended while not ready");
   a_async_read_pins: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_STROBE && !is_write |-> !o_shared_pin_a_n && o_shared_pin_c_n &&
      !o_shared_pin_b_n) else $error("async read pin roles wrong");
   a_sbsram_addr_strobe: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_XFER && is_sbsram && cnt == '0 |-> !o_shared_pin_a_n ##1 o_shared_pin_a_n)
      else $error("burst sram address strobe not single");
   a_sdram_act_cas: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_ACT |-> !o_shared_pin_b_n ##1 (o_shared_pin_b_n && !o_shared_pin_a_n))
      else $error("sdram row then column order wrong");
   a_burst_no_gap: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_XFER && cnt < len8 - SEQ_W'(1) |=> st == ST_XFER && cnt == $past(cnt) + SEQ_W'(1))
      else $error("gap inside burst");
   a_default_burst: assert property (@(posedge i_mem_clock_in) disable iff (!i_rst_b)
      st == ST_XFER && len_raw == '0 |-> len8 == SEQ_W'(BURST_WORDS))
      else $error("default burst not four words");
endmodule

// ---- emsq_mem_model.sv ----
// far-side memories: async sram on space 0, burst sram on space 1, sdram on space 2
`timescale 1ns/1ps
module emsq_mem_model (
   input wire logic i_clk,
   input wire logic [3:0] i_ce_n,
   input wire logic [3:0] i_be_n,
   input wire logic [19:0] i_addr,
   input wire logic [31:0] i_data,
   input wire logic i_oe_n,
   input wire logic i_a_n,
   input wire logic i_b_n,
   input wire logic i_c_n,
   output logic [31:0] o_data
);
   logic [31:0] mem [16];
   logic [31:0] word = '0, last = '0;
   logic [3:0] ptr = '0, wptr = '0;
   logic [2:0] k = '0;
   logic act = 0, wact = 0, drv = 0;
   // one more output register so read latency matches the sequencer's count
   logic [31:0] word_d = '0;
   logic drv_d = 0;
   // pin roles differ per memory type
   wire a_rd = !i_ce_n[0] && !i_b_n && !i_a_n;
   wire s_rd = !i_ce_n[1] && !i_a_n && !i_b_n;
   wire d_rd = !i_ce_n[2] && !i_a_n && i_b_n && i_c_n;
   wire s_wr = !(&i_ce_n[2:1]) && !i_a_n && !i_c_n;
   // a released bus flips every cycle so stale data never passes as valid
   assign o_data = a_rd ? mem[i_addr[3:0]] : drv_d ? word_d : ~last;
   task automatic put(input logic [3:0] a);
      for (int i = 0; i < 4; i++) begin
         if (!i_be_n[i]) mem[a][8*i+:8] <= i_data[8*i+:8];
      end
   endtask
   // async write lands on the strobe's rising edge
   always @(posedge i_c_n) if (!i_ce_n[0]) put(i_addr[3:0]);
   // the burst counter lives here: one address per burst
   always @(posedge i_clk) begin
      last <= o_data;
      word_d <= word;
      drv_d <= drv;
      drv <= 1'b0;
      if (s_wr) begin
         put(i_addr[3:0]);
         wptr <= i_addr[3:0] + 4'h1;
         wact <= 1'b1;
      end else if (wact && !(&i_ce_n) && !i_oe_n) begin
         put(wptr);
         wptr <= wptr + 4'h1;
      end else wact <= 1'b0;
      // a new strobe cuts a burst in progress
      if (s_rd || d_rd) begin
         ptr <= i_addr[3:0];
         k <= {2'b0, s_rd};
         act <= 1'b1;
         word <= mem[i_addr[3:0]];
         drv <= s_rd;
      end else if (act) begin
         word <= mem[ptr + {2'b0, k[1:0]}];
         drv <= 1'b1;
         k <= k + 3'd1;
         act <= k != 3'd3;
      end
   end
endmodule

// ---- emsq_top_bench.sv ----
// self-checking bench: wishbone driver, read-note queue, async pin timing monitor
`timescale 1ns/1ps
module emsq_top_bench;
   import emsq_pkg::*;
   logic i_clk = 0, i_mem_clock_in = 0, i_rst_b = 0, cyc = 0, stb = 0, we = 0, rdy = 1;
   logic stretch = 0;
   logic [7:0] adr = '0;
   logic [31:0] wdat = '0, rdat, mbus, lfsr = 32'h0e7a, a0, b0, wdat_m;
   logic [3:0] sel = '0, ce_n, be_n;
   logic [19:0] maddr;
   logic [63:0] note;
   logic [31:0] wv[4];
   logic oe_n, pa, pb, pc, ack, mclk;
   int bad_count = 0, compares = 0, pre = 0, sw = 0, post = 0, dpre = 0;
   int e_pre, e_sw, e_post, e_dpre;
   logic [63:0] expq[$];
   emsq_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_mem_clock_in(i_mem_clock_in), .o_mem_clock_out(mclk),
      .o_chip_space_enable_n(ce_n), .o_byte_lane_enable_n(be_n),
      .o_mem_word_address(maddr), .o_mem_data_bus(wdat_m), .o_mem_data_bus_oe_n(oe_n),
      .i_mem_data_bus(mbus), .o_shared_pin_a_n(pa), .o_shared_pin_b_n(pb),
      .o_shared_pin_c_n(pc), .i_async_ready_in(rdy));
   emsq_mem_model mem (.i_clk(mclk), .i_ce_n(ce_n), .i_be_n(be_n), .i_addr(maddr),
      .i_data(wdat_m), .i_oe_n(oe_n), .i_a_n(pa), .i_b_n(pb), .i_c_n(pc), .o_data(mbus));
   initial forever #20 i_clk = ~i_clk;
   // memory clock offset so its edges never line up with the bus clock
   initial begin
      #7;
      forever #16 i_mem_clock_in = ~i_mem_clock_in;
   end
   function automatic logic [31:0] nxt();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d, compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one classic cycle; request held until ack is seen at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] m, output logic [31:0] r);
      int n;
      if (!w) expq.push_back({m, d & m});
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 40) bad_count++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, 32'h0, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, e, 32'hffff_ffff, r);
   endtask
   // start one memory access, then poll busy under a bound
   task automatic go(input int sp, input int wa, input logic w, input int len);
      logic [31:0] r;
      int n;
      wr(OFS_ACC_ADDR, (32'(sp) << F_SPACE_LO) | (32'(wa) << F_WADDR_LO));
      wr(OFS_ACC_CMD, 32'h1 | (32'(w) << F_WRITE) | 32'h0f0 | (32'(len) << F_LEN_LO));
      n = 0;
      do begin
         wb(1'b0, OFS_STATUS, 32'h0, 32'h0, r);
         n++;
      end while (r[F_BUSY] !== 1'b0 && n < 200);
      if (n >= 200) bad_count++;
   endtask
   // the oldest read note meets each read answer
   always @(posedge i_clk) begin
      if (ack === 1'b1 && !we && expq.size() > 0) begin
         note = expq.pop_front();
         if (note[63:32] != 0) check(rdat & note[63:32], note[31:0]);
      end
   end
   // phase counter on the async space; checked when its chip enable rises
   always @(posedge i_mem_clock_in) begin
      if (!ce_n[0] && pa && pc && sw == 0) pre++;
      if (!ce_n[0] && (!pa || !pc)) sw++;
      if (!ce_n[0] && pa && pc && sw > 0) post++;
      if (!ce_n[0] && !oe_n && pc && sw == 0) dpre++;
      if (ce_n[0] && pre > 0) begin
         check(32'(pre), 32'(e_pre));
         check(32'(stretch ? sw > e_sw : sw == e_sw), 32'h1);
         check(32'(post), 32'(e_post));
         check(32'(dpre), 32'(e_dpre));
         pre = 0;
         sw = 0;
         post = 0;
         dpre = 0;
      end
   end
   initial begin
      #400000;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rd(8'h04, SPACE_CFG_RESET);
      rd(8'h40, 32'h0);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0);
      // async timings on space 0, burst sram on 1, sdram on 2
      wr(8'h00, 32'h0223_1320);
      wr(8'h04, 32'h0fff_fff1);
      wr(8'h08, 32'h0fff_fff2);
      a0 = nxt();
      b0 = nxt();
      {e_pre, e_sw, e_post, e_dpre} = {32'd3, 32'd2, 32'd2, 32'd2};
      wr({PAGE_WDATA, 4'h0}, a0);
      go(0, 5, 1'b1, 1);
      wr({PAGE_WDATA, 4'h0}, b0);
      go(0, 5, 1'b1, 1);
      {e_pre, e_sw, e_post, e_dpre} = {32'd2, 32'd3, 32'd1, 32'd0};
      go(0, 5, 1'b0, 1);
      rd({PAGE_RDATA, 4'h0}, b0);
      // ready held low stretches the strobe
      stretch = 1'b1;
      rdy <= 1'b0;
      fork
         go(0, 5, 1'b0, 1);
         begin
            // long enough to still be low when the last strobe period comes
            repeat (30) @(posedge i_mem_clock_in);
            rdy <= 1'b1;
         end
      join
      stretch = 1'b0;
      rd({PAGE_RDATA, 4'h0}, b0);
      for (int sp = 1; sp < 3; sp++) begin
         for (int i = 0; i < 4; i++) begin
            wv[i] = nxt();
            wr({PAGE_WDATA, 4'(4 * i)}, wv[i]);
         end
         go(sp, 8, 1'b1, 4);
         go(sp, 8, 1'b0, 0);
         for (int i = 0; i < 4; i++) rd({PAGE_RDATA, 4'(4 * i)}, wv[i]);
         go(sp, 9, 1'b0, 2);
         rd({PAGE_RDATA, 4'h0}, wv[1]);
         rd({PAGE_RDATA, 4'h4}, wv[2]);
      end
      final_report();
   end
endmodule
